// *** hdl/erc_ext_reg_ctrl.sv ***
// external regulator configuration, lock, mode and stage control
`include "erc_consts.svh"
module erc_ext_reg_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic softReset,
  input wire erc_pkg::erc_mode_t sbcMode,
  input wire erc_pkg::erc_cmd_t hostCmd,
  input wire logic ocClearReq,
  input wire logic mainRegOneOn,
  input wire logic batteryUvPin,
  input wire logic shuntThresholdPin,
  input wire logic baseRisePin,
  input wire logic baseFallPin,
  input wire logic outputUvPin,
  output erc_pkg::erc_drv_t regDrive,
  output erc_pkg::erc_cfg_t cfgLocked,
  output logic spiFailFlag,
  output logic ext_reg_overcurrent_flag,
  output logic ext_reg_undervoltage_flag,
  output logic ext_reg_standalone_enable,
  output logic ext_reg_load_share_select
);
  logic batteryUv;
  logic shuntHit;
  logic baseRise;
  logic baseFall;
  logic outUv;
  erc_pkg::erc_cfg_t cfg_r;
  logic voltSel_r;
  logic uvKeepOff_r;
  logic shareInStop_r;
  logic uvLatchedOff_r;
  logic hpStop_r;
  logic cfgWrite;
  logic regOn_nxt;
  logic hp_nxt;
  logic isNormal;
  logic isStop;

  erc_pin_sync u_sync_uv (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .pinIn(batteryUvPin), .level(batteryUv));
  erc_pin_sync u_sync_oc (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .pinIn(shuntThresholdPin), .level(shuntHit));
  erc_pin_sync u_sync_rise (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .pinIn(baseRisePin), .level(baseRise));
  erc_pin_sync u_sync_fall (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .pinIn(baseFallPin), .level(baseFall));
  erc_pin_sync u_sync_ouv (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .pinIn(outputUvPin), .level(outUv));

  assign isNormal = (sbcMode == erc_pkg::MODE_NORMAL);
  assign isStop = (sbcMode == erc_pkg::MODE_STOP);
  assign cfgWrite = hostCmd.wrStrobe;

  // configuration choice and lock; nrst is the power-on reset only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= erc_pkg::CFG_NONE;
    end else if (clkEn && cfgWrite && cfg_r == erc_pkg::CFG_NONE) begin
      if (hostCmd.loadShareSelect) begin
        cfg_r <= erc_pkg::CFG_LOADSHARE;
      end else if (hostCmd.standaloneEnable && isNormal) begin
        cfg_r <= erc_pkg::CFG_STANDALONE;
      end
    end
  end

  // stand-alone on/off and control bits; voltage select frozen by lock
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ext_reg_standalone_enable <= 1'b0;
      voltSel_r <= `ERC_VSEL_5V0;
      uvKeepOff_r <= 1'b0;
      shareInStop_r <= 1'b0;
    end else if (clkEn && softReset) begin
      ext_reg_standalone_enable <= 1'b0;
      uvKeepOff_r <= 1'b0;
      shareInStop_r <= 1'b0;
    end else if (clkEn && cfgWrite) begin
      uvKeepOff_r <= hostCmd.uvKeepOff;
      shareInStop_r <= hostCmd.shareInStop;
      if (cfg_r == erc_pkg::CFG_NONE) begin
        voltSel_r <= hostCmd.voltageSelect;
      end
      if (isNormal && cfg_r != erc_pkg::CFG_LOADSHARE &&
          !(cfg_r == erc_pkg::CFG_NONE && hostCmd.loadShareSelect)) begin
        ext_reg_standalone_enable <= hostCmd.standaloneEnable;
      end
    end
  end

  // load-share bit stays set once chosen
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ext_reg_load_share_select <= 1'b0;
    end else if (clkEn) begin
      ext_reg_load_share_select <= (cfg_r == erc_pkg::CFG_LOADSHARE) ||
        (cfgWrite && cfg_r == erc_pkg::CFG_NONE && hostCmd.loadShareSelect);
    end
  end

  // refused change after load-share lock raises the failure flag
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spiFailFlag <= 1'b0;
    end else if (clkEn) begin
      if (cfgWrite && cfg_r == erc_pkg::CFG_LOADSHARE &&
          (hostCmd.standaloneEnable || !hostCmd.loadShareSelect)) begin
        spiFailFlag <= 1'b1;
      end else if (softReset) begin
        spiFailFlag <= 1'b0;
      end
    end
  end

  // undervoltage switch-off latch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      uvLatchedOff_r <= 1'b0;
    end else if (clkEn) begin
      if (batteryUv && uvKeepOff_r) begin
        uvLatchedOff_r <= 1'b1;
      end else if (cfgWrite && !hostCmd.uvKeepOff) begin
        uvLatchedOff_r <= 1'b0;
      end
    end
  end

  // enable per mode
  always_comb begin
    regOn_nxt = 1'b0;
    case (sbcMode)
      erc_pkg::MODE_INIT: regOn_nxt = 1'b0;
      erc_pkg::MODE_FAILSAFE: regOn_nxt = 1'b0;
      erc_pkg::MODE_NORMAL: begin
        if (cfg_r == erc_pkg::CFG_LOADSHARE) begin
          regOn_nxt = 1'b1;
        end else begin
          regOn_nxt = (cfg_r == erc_pkg::CFG_STANDALONE) && ext_reg_standalone_enable;
        end
      end
      erc_pkg::MODE_STOP: begin
        if (cfg_r == erc_pkg::CFG_LOADSHARE) begin
          regOn_nxt = shareInStop_r;
        end else begin
          regOn_nxt = (cfg_r == erc_pkg::CFG_STANDALONE) && ext_reg_standalone_enable;
        end
      end
      erc_pkg::MODE_SLEEP, erc_pkg::MODE_RESTART: begin
        if (cfg_r == erc_pkg::CFG_LOADSHARE) begin
          regOn_nxt = mainRegOneOn;
        end else begin
          regOn_nxt = (cfg_r == erc_pkg::CFG_STANDALONE) && ext_reg_standalone_enable;
        end
      end
      default: regOn_nxt = 1'b0;
    endcase
    if (batteryUv || uvLatchedOff_r) begin
      regOn_nxt = 1'b0;
    end
  end

  // high-power stage hysteresis in Stop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hpStop_r <= 1'b0;
    end else if (clkEn) begin
      if (!isStop) begin
        hpStop_r <= 1'b0;
      end else if (baseRise) begin
        hpStop_r <= 1'b1;
      end else if (baseFall) begin
        hpStop_r <= 1'b0;
      end
    end
  end

  assign hp_nxt = isNormal || (isStop && (hpStop_r || baseRise));

  // drive outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regDrive <= '0;
      cfgLocked <= erc_pkg::CFG_NONE;
    end else if (clkEn) begin
      regDrive.regOn <= regOn_nxt;
      regDrive.outIs3v3 <= (cfg_r == erc_pkg::CFG_STANDALONE) &&
        (voltSel_r == `ERC_VSEL_3V3);
      regDrive.highPowerStage <= regOn_nxt && hp_nxt;
      regDrive.lowPowerStage <= regOn_nxt && !isNormal;
      cfgLocked <= cfg_r;
    end
  end

  // status flags: set wins over clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ext_reg_overcurrent_flag <= 1'b0;
      ext_reg_undervoltage_flag <= 1'b0;
    end else if (clkEn) begin
      if (cfg_r == erc_pkg::CFG_STANDALONE && shuntHit) begin
        ext_reg_overcurrent_flag <= 1'b1;
      end else if (ocClearReq) begin
        ext_reg_overcurrent_flag <= 1'b0;
      end
      if (cfg_r == erc_pkg::CFG_STANDALONE && outUv) begin
        ext_reg_undervoltage_flag <= 1'b1;
      end else if (ocClearReq) begin
        ext_reg_undervoltage_flag <= 1'b0;
      end
    end
  end

  property p_lock_kept;
    @(posedge sys_clk) disable iff (!nrst)
      cfg_r != erc_pkg::CFG_NONE |=> cfg_r == $past(cfg_r);
  endproperty
  a_lock_kept: assert property (p_lock_kept) else $error("lock changed");
  property p_ls_fail;
    @(posedge sys_clk) disable iff (!nrst)
      clkEn && cfgWrite && cfg_r == erc_pkg::CFG_LOADSHARE &&
      (hostCmd.standaloneEnable || !hostCmd.loadShareSelect) |=> spiFailFlag;
  endproperty
  a_ls_fail: assert property (p_ls_fail) else $error("no spi fail");
  property p_uv_off;
    @(posedge sys_clk) disable iff (!nrst)
      clkEn && batteryUv |=> !regDrive.regOn;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("on in undervoltage");
  property p_init_off;
    @(posedge sys_clk) disable iff (!nrst)
      clkEn && (isNormal == 1'b0) && (sbcMode == erc_pkg::MODE_INIT ||
      sbcMode == erc_pkg::MODE_FAILSAFE) |=> !regDrive.regOn;
  endproperty
  a_init_off: assert property (p_init_off) else $error("on in init");
  property p_normal_hp;
    @(posedge sys_clk) disable iff (!nrst)
      clkEn && isNormal |=> !regDrive.lowPowerStage;
  endproperty
  a_normal_hp: assert property (p_normal_hp) else $error("low stage in normal");
  property p_ls_5v;
    @(posedge sys_clk) disable iff (!nrst)
      cfgLocked == erc_pkg::CFG_LOADSHARE |-> !regDrive.outIs3v3;
  endproperty
  a_ls_5v: assert property (p_ls_5v) else $error("3v3 in load share");
  property p_stop_share;
    @(posedge sys_clk) disable iff (!nrst)
      clkEn && isStop && cfg_r == erc_pkg::CFG_LOADSHARE && !batteryUv &&
      !uvLatchedOff_r |=> regDrive.regOn == $past(shareInStop_r);
  endproperty
  a_stop_share: assert property (p_stop_share) else $error("stop share wrong");
  property p_sa_nofail;
    @(posedge sys_clk) disable iff (!nrst)
      clkEn && cfg_r == erc_pkg::CFG_STANDALONE && !spiFailFlag |=> !spiFailFlag;
  endproperty
  a_sa_nofail: assert property (p_sa_nofail) else $error("fail in stand-alone");
  c_ls_lock: cover property (@(posedge sys_clk) cfg_r == erc_pkg::CFG_LOADSHARE);
  c_sa_lock: cover property (@(posedge sys_clk) cfg_r == erc_pkg::CFG_STANDALONE);
  c_hp_stop: cover property (@(posedge sys_clk) isStop && regDrive.highPowerStage);
endmodule

// *** hdl/erc_consts.svh ***
// constants for the external regulator configuration control
`ifndef ERC_CONSTS_SVH
`define ERC_CONSTS_SVH
`define ERC_MODE_INIT 3'h0
`define ERC_MODE_NORMAL 3'h1
`define ERC_MODE_STOP 3'h2
`define ERC_MODE_SLEEP 3'h3
`define ERC_MODE_RESTART 3'h4
`define ERC_MODE_FAILSAFE 3'h5
`define ERC_VSEL_5V0 1'h0
`define ERC_VSEL_3V3 1'h1
`define ERC_SYNC_STAGES 3
`endif

// *** hdl/erc_pkg.sv ***
// types for the external regulator configuration control
package erc_pkg;
  typedef enum logic [2:0] {
    MODE_INIT = 3'h0,
    MODE_NORMAL = 3'h1,
    MODE_STOP = 3'h2,
    MODE_SLEEP = 3'h3,
    MODE_RESTART = 3'h4,
    MODE_FAILSAFE = 3'h5
  } erc_mode_t;
  typedef enum logic [1:0] {
    CFG_NONE = 2'h0,
    CFG_STANDALONE = 2'h1,
    CFG_LOADSHARE = 2'h2
  } erc_cfg_t;
  // host configuration write
  typedef struct packed {
    logic wrStrobe;
    logic standaloneEnable;
    logic loadShareSelect;
    logic voltageSelect;
    logic uvKeepOff;
    logic shareInStop;
  } erc_cmd_t;
  // regulator drive outputs
  typedef struct packed {
    logic regOn;
    logic outIs3v3;
    logic highPowerStage;
    logic lowPowerStage;
  } erc_drv_t;
endpackage

// *** hdl/erc_pin_sync.sv ***
// three-stage synchroniser for pin inputs with agreement filter
module erc_pin_sync (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic pinIn,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (clkEn) begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level <= 1'b0;
    end else if (clkEn && (s2_r == s3_r)) begin
      level <= s3_r;
    end
  end
endmodule

// *** tb/erc_host_model.sv ***
// host model issuing configuration writes and flag clears
module erc_host_model (
  input wire logic sys_clk,
  output erc_pkg::erc_cmd_t hostCmd,
  output logic ocClearReq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hostCmd = 6'h00;
    ocClearReq = 1'b0;
  end
  // one-cycle strobe, fields held afterwards, launched on the falling edge
  task automatic write(input logic en, input logic ls, input logic vs, input logic uvo,
    input logic sis);
    @(negedge sys_clk);
    hostCmd = {1'b1, en, ls, vs, uvo, sis};
    @(negedge sys_clk);
    hostCmd.wrStrobe = 1'b0;
  endtask
  // flags are cleared by a single pulse
  task automatic clearFlags;
    @(negedge sys_clk);
    ocClearReq = 1'b1;
    @(negedge sys_clk);
    ocClearReq = 1'b0;
  endtask
endmodule

// *** tb/test_erc_ext_reg_ctrl.sv ***
// self-checking bench for the external regulator control
`define CHK(got, exp) chk((got) === (exp));
module test_erc_ext_reg_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  logic softReset = 1'b0;
  logic mainRegOneOn = 1'b1;
  logic batteryUvPin = 1'b0;
  logic shuntThresholdPin = 1'b0;
  logic baseRisePin = 1'b0;
  logic baseFallPin = 1'b0;
  logic outputUvPin = 1'b0;
  logic ocClearReq;
  logic spiFail, ocFlag, uvFlag, saEn, lsSel;
  erc_pkg::erc_mode_t sbcMode = erc_pkg::MODE_INIT;
  erc_pkg::erc_cmd_t hostCmd;
  erc_pkg::erc_drv_t drv;
  erc_pkg::erc_cfg_t cfgLocked;
  int errorCnt = 0;
  int compares = 0;
  int cycles = 0;
  always #2 sys_clk = ~sys_clk;
  erc_host_model host (.sys_clk(sys_clk), .hostCmd(hostCmd), .ocClearReq(ocClearReq));
  erc_ext_reg_ctrl dut (
    .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .softReset(softReset),
    .sbcMode(sbcMode), .hostCmd(hostCmd), .ocClearReq(ocClearReq),
    .mainRegOneOn(mainRegOneOn), .batteryUvPin(batteryUvPin),
    .shuntThresholdPin(shuntThresholdPin), .baseRisePin(baseRisePin),
    .baseFallPin(baseFallPin), .outputUvPin(outputUvPin), .regDrive(drv),
    .cfgLocked(cfgLocked), .spiFailFlag(spiFail), .ext_reg_overcurrent_flag(ocFlag),
    .ext_reg_undervoltage_flag(uvFlag), .ext_reg_standalone_enable(saEn),
    .ext_reg_load_share_select(lsSel)
  );
  task automatic chk(input bit ok);
    compares++;
    if (!ok) begin
      errorCnt++;
      $display("mismatch at %0t: output differs from expected value", $time);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic setMode(input erc_pkg::erc_mode_t m);
    sbcMode = m;
    step(3);
  endtask
  task automatic summarize;
    $display("errors %0d compares %0d", errorCnt, compares);
    if (errorCnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errorCnt++;
      summarize();
    end
  end
  initial begin
    step(16);
    nrst = 1'b1;
    step(1);
    `CHK(drv, 4'h0) `CHK(cfgLocked, erc_pkg::CFG_NONE)
    host.write(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    step(3);
    `CHK(cfgLocked, erc_pkg::CFG_NONE) `CHK(drv.regOn, 1'b0)
    setMode(erc_pkg::MODE_NORMAL);
    host.write(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    step(3);
    `CHK(cfgLocked, erc_pkg::CFG_STANDALONE) `CHK(saEn, 1'b1)
    `CHK(drv, 4'hE)
    host.write(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    step(3);
    `CHK(cfgLocked, erc_pkg::CFG_STANDALONE) `CHK(spiFail, 1'b0)
    `CHK(drv, 4'hE) `CHK(lsSel, 1'b0)
    batteryUvPin = 1'b1;
    step(8);
    `CHK(drv.regOn, 1'b0)
    batteryUvPin = 1'b0;
    step(8);
    `CHK(drv.regOn, 1'b1)
    host.write(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    batteryUvPin = 1'b1;
    step(8);
    batteryUvPin = 1'b0;
    step(8);
    `CHK(drv.regOn, 1'b0)
    host.write(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    step(3);
    `CHK(drv.regOn, 1'b1)
    shuntThresholdPin = 1'b1;
    outputUvPin = 1'b1;
    step(8);
    `CHK(ocFlag, 1'b1) `CHK(uvFlag, 1'b1)
    host.clearFlags();
    step(3);
    `CHK(ocFlag, 1'b1)
    shuntThresholdPin = 1'b0;
    outputUvPin = 1'b0;
    step(8);
    host.clearFlags();
    step(3);
    `CHK(ocFlag, 1'b0) `CHK(uvFlag, 1'b0)
    setMode(erc_pkg::MODE_STOP);
    `CHK(drv, 4'hD)
    baseRisePin = 1'b1;
    step(8);
    `CHK(drv.highPowerStage, 1'b1)
    baseRisePin = 1'b0;
    baseFallPin = 1'b1;
    step(8);
    `CHK(drv.highPowerStage, 1'b0)
    baseFallPin = 1'b0;
    mainRegOneOn = 1'b0;
    setMode(erc_pkg::MODE_SLEEP);
    `CHK(drv.regOn, 1'b1)
    mainRegOneOn = 1'b1;
    setMode(erc_pkg::MODE_RESTART);
    `CHK(drv.regOn, 1'b1)
    setMode(erc_pkg::MODE_FAILSAFE);
    `CHK(drv.regOn, 1'b0)
    setMode(erc_pkg::MODE_INIT);
    `CHK(drv.regOn, 1'b0)
    softReset = 1'b1;
    step(2);
    softReset = 1'b0;
    step(3);
    `CHK(cfgLocked, erc_pkg::CFG_STANDALONE)
    nrst = 1'b0;
    step(2);
    nrst = 1'b1;
    step(1);
    `CHK(cfgLocked, erc_pkg::CFG_NONE)
    setMode(erc_pkg::MODE_NORMAL);
    host.write(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    step(3);
    `CHK(cfgLocked, erc_pkg::CFG_LOADSHARE) `CHK(lsSel, 1'b1)
    `CHK(drv, 4'hA)
    host.write(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    step(3);
    `CHK(spiFail, 1'b1) `CHK(cfgLocked, erc_pkg::CFG_LOADSHARE)
    softReset = 1'b1;
    step(2);
    softReset = 1'b0;
    step(1);
    `CHK(spiFail, 1'b0) `CHK(cfgLocked, erc_pkg::CFG_LOADSHARE)
    host.write(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    step(3);
    `CHK(spiFail, 1'b1) `CHK(lsSel, 1'b1)
    setMode(erc_pkg::MODE_STOP);
    `CHK(drv.regOn, 1'b0) `CHK(lsSel, 1'b1)
    setMode(erc_pkg::MODE_NORMAL);
    `CHK(drv.regOn, 1'b1)
    clkEn = 1'b0;
    setMode(erc_pkg::MODE_STOP);
    `CHK(drv.regOn, 1'b1)
    clkEn = 1'b1;
    step(2);
    `CHK(drv.regOn, 1'b0)
    host.write(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    setMode(erc_pkg::MODE_STOP);
    `CHK(drv.regOn, 1'b1)
    mainRegOneOn = 1'b0;
    setMode(erc_pkg::MODE_SLEEP);
    `CHK(drv.regOn, 1'b0)
    mainRegOneOn = 1'b1;
    setMode(erc_pkg::MODE_RESTART);
    `CHK(drv.regOn, 1'b1)
    setMode(erc_pkg::MODE_FAILSAFE);
    `CHK(drv.regOn, 1'b0)
    summarize();
  end
endmodule
